// [hw/msd_ctrl.sv]
// MAC speed and duplex control register bank on APB
`timescale 1ns/10ps
module msd_ctrl
  import msd_pkg::*;
#(
  parameter int MAC_SOFT_RESET_CYC = MSD_MAC_SOFT_RESET_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire msd_image_type eeprom_img_i,
  input wire msd_image_type otp_img_i,
  input wire logic img_load_i,
  input wire logic usb_reset_i,
  input wire logic soft_lite_reset_i,
  input wire logic det_valid_i,
  input wire logic det_duplex_i,
  input wire logic [1:0] det_speed_i,
  output msd_mac_cfg_type mac_cfg_o,
  output logic mac_reset_o
);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  if (MAC_SOFT_RESET_CYC < 1 || MAC_SOFT_RESET_CYC > 255) begin : g_bad_cyc
    $error("MAC_SOFT_RESET_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Full address compare: misaligned offsets fall to the error answer
  function automatic logic msd_hit(input logic [11:0] addr,
                                   input logic [11:0] offs);
    return addr == offs;
  endfunction

  // An unprogrammed image falls back to the built-in defaults
  function automatic msd_image_type msd_img_dflt(input msd_image_type img);
    msd_image_type res;
    res = img;
    if (!img.valid) begin
      res.auto_duplex = MSD_ADD_RST;
      res.auto_speed = MSD_ASD_RST;
      res.duplex = MSD_DPX_RST;
      res.speed = MSD_SPD_RST;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic acc = psel_i & penable_i;
  wire logic apb_setup = psel_i & ~penable_i;
  wire logic hit_ctrl = msd_hit(paddr_i, MSD_CTRL_OFFS);
  wire logic hit_stat = msd_hit(paddr_i, MSD_STAT_OFFS);
  wire logic hit_any = hit_ctrl | hit_stat;
  wire logic wr_ctrl = acc & pwrite_i & hit_ctrl & pstrb_i[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic dpx_ff;
  logic [1:0] spd_ff;
  logic add_ff;
  logic asd_ff;
  logic det_dpx_ff;
  logic [1:0] det_spd_ff;
  msd_image_type img_ff;
  logic [7:0] mac_soft_reset_cnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  msd_mac_cfg_type cfg_ff;
  logic mac_soft_reset_ff;

  // EEPROM wins over OTP; unprogrammed image leaves documented defaults
  wire msd_image_type src_img = eeprom_img_i.valid ? eeprom_img_i :
                                otp_img_i; // RULE9
  wire logic restore = usb_reset_i | soft_lite_reset_i; // RULE10
  wire logic ld = img_load_i | restore;
  wire msd_image_type use_img = img_load_i ? src_img : img_ff;
  wire msd_image_type dflt_img = msd_img_dflt(use_img);
  wire logic img_dpx = dflt_img.duplex; // RULE9
  wire logic [1:0] img_spd = dflt_img.speed; // RULE9
  wire logic img_add = dflt_img.auto_duplex; // RULE11
  wire logic img_asd = dflt_img.auto_speed; // RULE12

  // Effective values: detected when auto, software copy when manual
  wire logic eff_dpx = add_ff ? det_dpx_ff : dpx_ff; // RULE1
  wire logic [1:0] eff_spd = asd_ff ? det_spd_ff : spd_ff; // RULE4
  wire logic is_gig = eff_spd == MSD_SPD_1000; // RULE6
  // Half duplex unsupported at gigabit
  wire logic full_dpx = eff_dpx | is_gig; // RULE2 RULE3

  // Software writes to read-only fields are dropped when auto is on
  wire logic nxt_dpx = ld ? img_dpx :
                       (wr_ctrl & ~add_ff) ? pwdata_i[MSD_DPX_BIT] :
                       dpx_ff; // RULE1
  // Reserved code 11 ignored, field keeps its value
  wire logic spd_ok = pwdata_i[MSD_SPD_LSB+1 -: 2] != 2'h3;
  wire logic [1:0] nxt_spd = ld ? img_spd :
                             (wr_ctrl & ~asd_ff & spd_ok) ?
                             pwdata_i[MSD_SPD_LSB+1 -: 2] :
                             spd_ff; // RULE4 RULE5
  wire logic nxt_add = ld ? img_add :
                       wr_ctrl ? pwdata_i[MSD_ADD_BIT] : add_ff;
  wire logic nxt_asd = ld ? img_asd :
                       wr_ctrl ? pwdata_i[MSD_ASD_BIT] : asd_ff;

  wire logic mac_soft_reset_busy = mac_soft_reset_cnt_ff != 8'h00;
  wire logic mac_soft_reset_req = wr_ctrl & pwdata_i[MSD_RST_BIT]; // RULE8
  wire logic [7:0] nxt_mac_soft_reset_cnt = mac_soft_reset_req ? 8'(MAC_SOFT_RESET_CYC) :
                                  mac_soft_reset_busy ? mac_soft_reset_cnt_ff - 8'h01 :
                                  8'h00; // RULE8

  wire logic [31:0] ctrl_rd = {26'h0, add_ff, asd_ff, eff_dpx, eff_spd,
                               mac_soft_reset_busy}; // RULE8
  wire logic [31:0] stat_rd = {29'h0, mac_soft_reset_busy, cfg_ff.full_duplex,
                               cfg_ff.gmii_sel};
  wire logic [31:0] nxt_prdata = hit_ctrl ? ctrl_rd :
                                 hit_stat ? stat_rd : 32'h0;

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dpx_ff <= MSD_DPX_RST;
      spd_ff <= MSD_SPD_RST;
      add_ff <= MSD_ADD_RST;
      asd_ff <= MSD_ASD_RST;
    end else begin
      dpx_ff <= nxt_dpx; // RULE1
      spd_ff <= nxt_spd; // RULE4
      add_ff <= nxt_add; // RULE11
      asd_ff <= nxt_asd; // RULE12
    end
  end

  // Last image kept so later USB and lite resets can restore it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      img_ff <= '0;
    end else if (img_load_i) begin
      img_ff <= src_img; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // MAC reset timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mac_soft_reset_cnt_ff <= 8'h00;
    end else begin
      mac_soft_reset_cnt_ff <= nxt_mac_soft_reset_cnt; // RULE8
    end
  end

  // Pin follows the request at once and drops with the last count
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mac_soft_reset_ff <= 1'b0;
    end else begin
      mac_soft_reset_ff <= mac_soft_reset_req | (mac_soft_reset_cnt_ff > 8'h01); // RULE8
    end
  end

  // ----------------------------------------------------------------
  // Detected values
  // ----------------------------------------------------------------
  // Latched so that auto mode keeps reporting the last one
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      det_dpx_ff <= MSD_DPX_RST;
      det_spd_ff <= MSD_SPD_RST;
    end else if (det_valid_i) begin
      det_dpx_ff <= det_duplex_i;
      det_spd_ff <= det_speed_i;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Zero wait states: ready stands for the access cycle only
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= apb_setup & ~pready_ff;
      pslverr_ff <= apb_setup & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // MAC settings
  // ----------------------------------------------------------------
  // One cycle behind the state, so the MAC sees a registered word
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.full_duplex <= full_dpx; // RULE2 RULE3
      cfg_ff.gmii_sel <= is_gig; // RULE5
      cfg_ff.speed <= eff_spd; // RULE6
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign mac_cfg_o = cfg_ff;
  assign mac_reset_o = mac_soft_reset_ff;

endmodule // msd_ctrl

// [hw/msd_pkg.sv]
// Package for the MAC speed and duplex control register bank
//
// Contract
// RULE1: Auto duplex off: duplex bit writable and drives MAC; on: reads detected duplex.
// RULE2: Duplex bit set means full duplex; clear means half duplex.
// RULE3: At 1000 megabit the MAC never runs half duplex.
// RULE4: Auto speed off: speed field writable and drives MAC; on: reads detected speed.
// RULE5: Speed field picks 10 or 100 over MII, or 1000 over gigabit interface.
// RULE6: Speed code 00 is 10, 01 is 100, 10 is 1000 megabit.
// RULE7: Software leaves duplex and speed alone while receiver or transmitter enabled.
// RULE8: Writing one to MAC reset resets MAC; self-clears when done; reads zero. Here bit 0 reads the busy flag, one while the reset runs.
// RULE9: Duplex and speed defaults come from EEPROM, else OTP, else zero.
// RULE10: USB or soft lite reset restores duplex and speed from loaded image.
// RULE11: Auto duplex enable defaults from image flag, else one, also on resets.
// RULE12: Auto speed enable defaults from image flag, else zero, also on resets.
// RULE13: After manual change software updates PHY EEE setup and reruns negotiation.
package msd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] MSD_CTRL_OFFS = 12'h000;
  localparam logic [11:0] MSD_STAT_OFFS = 12'h004;

  // ----------------------------------------------------------------
  // Field positions in the control word
  // ----------------------------------------------------------------
  localparam int MSD_RST_BIT = 0;
  localparam int MSD_SPD_LSB = 1;
  localparam int MSD_DPX_BIT = 3;
  localparam int MSD_ASD_BIT = 4;
  localparam int MSD_ADD_BIT = 5;
  // Status word bits
  localparam int MSD_ST_GMII_BIT = 0;
  localparam int MSD_ST_FULL_BIT = 1;
  localparam int MSD_ST_BUSY_BIT = 2;

  // ----------------------------------------------------------------
  // Values without any programmed image
  // ----------------------------------------------------------------
  localparam logic MSD_DPX_RST = 1'b0;
  localparam logic [1:0] MSD_SPD_RST = 2'h0;
  localparam logic MSD_ADD_RST = 1'b1;
  localparam logic MSD_ASD_RST = 1'b0;

  // Cycles the MAC reset is held once requested
  localparam int MSD_MAC_SOFT_RESET_CYC = 16;

  typedef enum logic [1:0] {
    MSD_SPD_10 = 2'h0,
    MSD_SPD_100 = 2'h1,
    MSD_SPD_1000 = 2'h2
  } msd_speed_type;

  // Configuration image as loaded from EEPROM or OTP
  typedef struct packed {
    logic valid;
    logic auto_duplex;
    logic auto_speed;
    logic duplex;
    logic [1:0] speed;
  } msd_image_type;

  // Settings delivered to the MAC
  typedef struct packed {
    logic full_duplex;
    logic gmii_sel;
    logic [1:0] speed;
  } msd_mac_cfg_type;

endpackage : msd_pkg

// [sim/msd_ctrl_properties.sv]
// Checker for the speed and duplex control bank
`timescale 1ns/10ps
module msd_ctrl_chk
  import msd_pkg::*;
#(
  parameter int MAC_SOFT_RESET_CYC = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic img_load_i,
  input wire logic usb_reset_i,
  input wire logic soft_lite_reset_i,
  input wire logic det_valid_i,
  input logic pready_o,
  input logic pslverr_o,
  input msd_mac_cfg_type mac_cfg_o,
  input logic mac_reset_o
);
  // Quiet: nothing that may legally move the settings
  wire quiet = !(psel_i | img_load_i | usb_reset_i | soft_lite_reset_i
    | det_valid_i);
  // Length of the current MAC reset pulse
  logic [8:0] rst_len;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_len <= 9'h000;
    end else if (mac_reset_o) begin
      rst_len <= rst_len + 9'h001;
    end else begin
      rst_len <= 9'h000;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_gig_full; mac_cfg_o.gmii_sel |-> mac_cfg_o.full_duplex;
  endproperty
  a_gig_full: assert property (p_gig_full) else $error("half at gig");
  property p_gig_sel;
    mac_cfg_o.gmii_sel == (mac_cfg_o.speed == MSD_SPD_1000);
  endproperty
  a_gig_sel: assert property (p_gig_sel) else $error("gmii sel bad");
  property p_spd_ok; mac_cfg_o.speed != 2'h3; endproperty
  a_spd_ok: assert property (p_spd_ok) else $error("speed code 3");
  property p_quiet; quiet [*2] |=> $stable(mac_cfg_o); endproperty
  a_quiet: assert property (p_quiet) else $error("cfg moved");
  property p_rst_hold; $rose(mac_reset_o) |-> mac_reset_o [*2]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset short");
  property p_rst_end; $rose(mac_reset_o) |-> ##[1:256] !mac_reset_o;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("reset stuck");
  property p_rst_len; $fell(mac_reset_o) |-> rst_len >= 9'(MAC_SOFT_RESET_CYC);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length");
  property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_rdy_one; pready_o |=> !pready_o; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule // msd_ctrl_chk
bind msd_ctrl msd_ctrl_chk #(.MAC_SOFT_RESET_CYC(MAC_SOFT_RESET_CYC)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .img_load_i(img_load_i), .usb_reset_i(usb_reset_i),
  .soft_lite_reset_i(soft_lite_reset_i), .det_valid_i(det_valid_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mac_cfg_o(mac_cfg_o),
  .mac_reset_o(mac_reset_o));

// [sim/msd_ctrl_tb.sv]
// Bench for the speed and duplex control bank
`timescale 1ns/10ps
module msd_ctrl_tb;
  import msd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, rd, got;
  logic [3:0] stb = 4'hF, ev = 4'h0;
  logic rdy, err, ge, mac_soft_reset, dd = 1'b0;
  logic [1:0] ds = 2'h0;
  msd_image_type eep = '0, otp = '0;
  msd_mac_cfg_type cfg;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #5 clk = ~clk;
  // Count of 4 keeps the busy window wide enough to read back
  msd_ctrl #(.MAC_SOFT_RESET_CYC(4)) DUT (
    .core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(adr), .pwdata_i(wd), .pstrb_i(stb),
    .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .eeprom_img_i(eep),
    .otp_img_i(otp), .img_load_i(ev[3]), .usb_reset_i(ev[2]),
    .soft_lite_reset_i(ev[1]), .det_valid_i(ev[0]), .det_duplex_i(dd),
    .det_speed_i(ds), .mac_cfg_o(cfg), .mac_reset_o(mac_soft_reset));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    got = rd;
    ge = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [11:0] a,
                     input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    cmp(n, e, got & m);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk("ctrl_rst", 12'h000, 32'h20, 32'h3F);
    chk("stat_rst", 12'h004, 32'h0, 32'h7);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h00);
    apb(1'b1, 12'h000, 32'h0A);
    chk("ctrl_man", 12'h000, 32'h0A, 32'h3F);
    chk("stat_full", 12'h004, 32'h2, 32'h3);
    apb(1'b1, 12'h000, 32'h04);
    chk("stat_gig", 12'h004, 32'h3, 32'h3);
    cmp("mac_cfg", 32'hE, {28'h0, cfg});
    apb(1'b1, 12'h000, 32'h06);
    chk("spd_11", 12'h000, 32'h4, 32'h6);
    stb <= 4'h0;
    apb(1'b1, 12'h000, 32'h00);
    stb <= 4'hF;
    chk("strb0", 12'h000, 32'h4, 32'h6);
    $display("test manual done");
    dd <= 1'b1;
    ds <= 2'h1;
    pulse(4'h1);
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h000, 32'h14);
    chk("auto_spd", 12'h000, 32'h12, 32'h3E);
    apb(1'b1, 12'h000, 32'h30);
    chk("auto_dpx", 12'h000, 32'h3A, 32'h3E);
    $display("test auto done");
    eep <= '{1'b1, 1'b0, 1'b0, 1'b1, 2'h1};
    otp <= '{1'b1, 1'b1, 1'b1, 1'b0, 2'h2};
    pulse(4'h8);
    chk("img_eep", 12'h000, 32'h0A, 32'h3E);
    apb(1'b1, 12'h000, 32'h04);
    pulse(4'h4);
    chk("usb_rst", 12'h000, 32'h0A, 32'h3E);
    eep <= '0;
    pulse(4'h8);
    chk("img_otp", 12'h000, 32'h3A, 32'h3E);
    apb(1'b1, 12'h000, 32'h00);
    pulse(4'h2);
    chk("lite_rst", 12'h000, 32'h3A, 32'h3E);
    otp <= '0;
    pulse(4'h8);
    chk("img_none", 12'h000, 32'h28, 32'h3E);
    $display("test image done");
    apb(1'b1, 12'h000, 32'h21);
    @(posedge clk);
    cmp("mac_rst_on", 32'h1, {31'h0, mac_soft_reset});
    chk("mac_soft_reset_busy", 12'h004, 32'h4, 32'h4);
    repeat (10) @(posedge clk);
    chk("mac_soft_reset_done", 12'h000, 32'h0, 32'h1);
    cmp("mac_rst_off", 32'h0, {31'h0, mac_soft_reset});
    cmp("cfg_10", 32'h8, {28'h0, cfg});
    apb(1'b0, 12'h008, 32'h0);
    cmp("slverr", 32'h1, {31'h0, ge});
    $display("test reset bit and map done");
    stop_test();
  end
endmodule // msd_ctrl_tb
